/* logic/hlcs_pkg.sv */
// shared constants and types of the host link control sequencer
// assumes one clock at 250 MHz and a synchronous, active-low reset
`default_nettype none

package hlcs_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 4;
   localparam int CMD_EXEC_NS     = 40;
   localparam int CMD_EXEC_CYCLES = (CMD_EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CMD_CNT_LAST = 4'(CMD_EXEC_CYCLES - 1);

   // ----------------------------------------------------------------
   // buffers
   // ----------------------------------------------------------------
   localparam logic [5:0] TX_DEPTH = 6'h21;
   localparam logic [5:0] RX_DEPTH = 6'h28;
   localparam logic [5:0] PTR_ZERO = 6'h00;

   // ----------------------------------------------------------------
   // control register bits and command codes
   // ----------------------------------------------------------------
   localparam int         CTRL_SOFT_RESET_BIT = 0;
   localparam int         CTRL_STANDBY_OFF_BIT = 1;
   localparam logic [7:0] CMD_TX_CLEAR        = 8'h10;
   localparam logic [7:0] CMD_SLAVE_TX        = 8'h0B;
   localparam logic [7:0] CMD_SLAVE_TX_CONT   = 8'h0C;
   localparam logic [7:0] CMD_MASTER_TX       = 8'h01;
   localparam logic [7:0] CMD_MASTER_TX_RESUME = 8'h02;
   localparam logic [7:0] CMD_MASTER_RX       = 8'h03;
   localparam logic [7:0] CMD_SLAVE_RX_ON     = 8'h04;
   localparam logic [7:0] CMD_SLAVE_RX_OFF    = 8'h05;

   // ----------------------------------------------------------------
   // return codes
   // ----------------------------------------------------------------
   localparam logic [3:0] RC_ERASED  = 4'hF;
   localparam logic [3:0] RC_REP_A   = 4'h1;
   localparam logic [3:0] RC_REP_B   = 4'h5;
   localparam logic [3:0] RC_REP_SLV = 4'h9;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_STANDBY = 3'h1,
      ST_IDLE    = 3'h2,
      ST_EXEC    = 3'h4
   } hlcs_state_t;

   typedef struct packed {
      logic cmd_exec;
      logic standby;
      logic master_req;
      logic slave_tx_req;
      logic slave_rx_en;
   } hlcs_flag_t;

   typedef struct packed {
      logic [3:0] master;
      logic [3:0] slave;
   } hlcs_rc_t;

   // codes that may repeat back to back
   function automatic logic hlcs_repeatable(input logic [3:0] code, input logic is_slave);
      hlcs_repeatable = (code == RC_REP_A) || (code == RC_REP_B) || (is_slave && code == RC_REP_SLV);
   endfunction

endpackage

`default_nettype wire

/* logic/hlcs_rc_slot.sv */
// one return-code slot: holds the code and a sticky new-code flag
// assumes core reset already merges pin and soft reset
`default_nettype none

module hlcs_rc_slot #(
   parameter bit IS_SLAVE = 1'b0
) (
   // clock, reset, enable
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       ce_in,
   // event from the link
   input  wire logic       event_in,
   input  wire logic [3:0] code_in,
   // read acknowledge
   input  wire logic       ack_in,
   // held code and flag
   output logic      [3:0] code_out,
   output logic            new_out
);

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   // ----------------------------------------------------------------
   // code store
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         code_out <= hlcs_pkg::RC_ERASED;
      end else if (ce_in) begin
         if (event_in) begin
            code_out <= code_in;
         end else if (ack_in && new_out && hlcs_pkg::hlcs_repeatable(code_out, IS_SLAVE)) begin
            code_out <= hlcs_pkg::RC_ERASED; // see R9 see R10
         end
      end
   end

   // new flag stays until read; event wins over read
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         new_out <= 1'b0;
      end else if (ce_in) begin
         if (event_in) begin
            new_out <= 1'b1; // see R6
         end else if (ack_in) begin
            new_out <= 1'b0;
         end
      end
   end

   AST_RC_ERASE: assert property (ce_in && ack_in && new_out && !event_in // see R9 see R10
         && hlcs_pkg::hlcs_repeatable(code_out, IS_SLAVE) |=> code_out == hlcs_pkg::RC_ERASED)
      else $error("repeatable code not erased after read");

   AST_RC_EVENT: assert property (ce_in && event_in |=> new_out && code_out == $past(code_in)) // see R9
      else $error("return code event lost");

endmodule

`default_nettype wire

/* logic/hlcs_host_link_ctrl.sv */
// host-facing control sequencer of the bus protocol controller
// assumes all inputs synchronous to ref_clk_in; link side is a plain strobe port
`default_nettype none

// How it works
// R1 - host reinitialises on start and crash
// R2 - reset by pin low or soft bit
// R3 - reset enters standby until host releases
// R4 - host waits command-executing low before commands
// R5 - host masks interrupt, reads flags, codes
// R6 - pending flags survive until serviced
// R7 - master code valid on change or idle
// R8 - slave code valid on change or idle
// R9 - repeated master codes erased to 1111
// R10 - repeated slave codes erased to 1111
// R11 - host rings reception events with pointers
// R12 - host flag init clears flags, pointers
// R13 - host services requests in fixed order
// R14 - commands set lock, buffers, comms, options
// R15 - master transmit, resume, receive supported
// R16 - receive buffer read only when nonempty
// R17 - command 00010000 clears transmit buffer
// R18 - slave transmit command needs loaded data
// R19 - host re-enables interrupt after updates
module hlcs_host_link_ctrl (
   // clock, reset, enable
   input  wire logic               ref_clk_in,
   input  wire logic               rst_n_in,
   input  wire logic               ce_in,
   // control register write
   input  wire logic               ctrl_wr_in,
   input  wire logic [7:0]         ctrl_data_in,
   // command register write
   input  wire logic               cmd_wr_in,
   input  wire logic [7:0]         cmd_code_in,
   // flags and status
   output hlcs_pkg::hlcs_flag_t    flags_out,
   output logic                    tx_full_out,
   output logic                    rx_empty_out,
   // transmit buffer
   input  wire logic               tx_wr_in,
   input  wire logic [7:0]         tx_byte_in,
   input  wire logic               tx_rd_in,
   output logic      [7:0]         tx_byte_out,
   // receive buffer
   input  wire logic               rx_wr_in,
   input  wire logic [7:0]         rx_byte_in,
   input  wire logic               rx_rd_in,
   output logic      [7:0]         rx_byte_out,
   // link completion events
   input  wire logic               master_done_in,
   input  wire logic [3:0]         master_code_in,
   input  wire logic               slave_done_in,
   input  wire logic [3:0]         slave_code_in,
   // return code register
   input  wire logic               rc_rd_in,
   output hlcs_pkg::hlcs_rc_t      rc_out,
   output logic      [1:0]         rc_new_out,
   output logic                    irq_out
);

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   function automatic logic [5:0] next_ptr(input logic [5:0] p, input logic [5:0] depth);
      next_ptr = (p == 6'(depth - 6'h01)) ? hlcs_pkg::PTR_ZERO : 6'(p + 6'h01);
   endfunction

   hlcs_pkg::hlcs_state_t state_r;
   logic                  soft_rst_r;
   logic                  core_rst_n;
   logic [3:0]            cnt_r;
   logic [7:0]            cmd_r;
   logic                  done;
   logic                  master_req_r;
   logic                  slave_tx_req_r;
   logic                  slave_rx_en_r;
   logic [7:0]            tx_mem [0:32];
   logic [7:0]            rx_mem [0:39];
   logic [5:0]            tx_wp_r, tx_rp_r, tx_cnt_r;
   logic [5:0]            rx_wp_r, rx_rp_r, rx_cnt_r;
   logic                  tx_push, tx_pop, rx_push, rx_pop, tx_clear;
   logic [1:0]            slot_ev;
   logic [3:0]            slot_code [0:1];
   logic [3:0]            slot_out [0:1];

   localparam logic [5:0] PTR_ZERO_C = hlcs_pkg::PTR_ZERO;

   // ----------------------------------------------------------------
   // reset: pin or soft reset bit
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         soft_rst_r <= 1'b0;
      end else if (ce_in) begin
         soft_rst_r <= ctrl_wr_in && ctrl_data_in[hlcs_pkg::CTRL_SOFT_RESET_BIT]; // see R2
      end
   end

   assign core_rst_n = rst_n_in && !soft_rst_r; // see R2

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (!core_rst_n) begin
         state_r <= hlcs_pkg::ST_STANDBY; // see R3
         cnt_r   <= 4'h0;
         cmd_r   <= 8'h00;
      end else if (ce_in) begin
         case (state_r)
            hlcs_pkg::ST_STANDBY: begin
               if (ctrl_wr_in && ctrl_data_in[hlcs_pkg::CTRL_STANDBY_OFF_BIT]) begin
                  state_r <= hlcs_pkg::ST_IDLE; // see R3
               end
            end
            hlcs_pkg::ST_IDLE: begin
               if (cmd_wr_in) begin
                  state_r <= hlcs_pkg::ST_EXEC;
                  cmd_r   <= cmd_code_in;
                  cnt_r   <= hlcs_pkg::CMD_CNT_LAST;
               end
            end
            hlcs_pkg::ST_EXEC: begin
               // writes while busy are dropped
               if (cnt_r == 4'h0) begin
                  state_r <= hlcs_pkg::ST_IDLE; // see R4
               end else begin
                  cnt_r <= 4'(cnt_r - 4'h1);
               end
            end
            default: begin
               state_r <= hlcs_pkg::ST_STANDBY;
            end
         endcase
      end
   end

   assign done     = ce_in && state_r == hlcs_pkg::ST_EXEC && cnt_r == 4'h0;
   assign tx_clear = done && cmd_r == hlcs_pkg::CMD_TX_CLEAR; // see R17

   // ----------------------------------------------------------------
   // request bits; set wins over link completion
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (!core_rst_n) begin
         master_req_r <= 1'b0;
      end else if (done && (cmd_r == hlcs_pkg::CMD_MASTER_TX || cmd_r == hlcs_pkg::CMD_MASTER_TX_RESUME
                            || cmd_r == hlcs_pkg::CMD_MASTER_RX)) begin
         master_req_r <= 1'b1;
      end else if (ce_in && master_done_in) begin
         master_req_r <= 1'b0; // see R7
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!core_rst_n) begin
         slave_tx_req_r <= 1'b0;
      end else if (done && (cmd_r == hlcs_pkg::CMD_SLAVE_TX || cmd_r == hlcs_pkg::CMD_SLAVE_TX_CONT)
                   && tx_cnt_r != PTR_ZERO_C) begin
         slave_tx_req_r <= 1'b1; // see R18
      end else if (ce_in && slave_done_in) begin
         slave_tx_req_r <= 1'b0; // see R8
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!core_rst_n) begin
         slave_rx_en_r <= 1'b0;
      end else if (done && cmd_r == hlcs_pkg::CMD_SLAVE_RX_ON) begin
         slave_rx_en_r <= 1'b1;
      end else if (done && cmd_r == hlcs_pkg::CMD_SLAVE_RX_OFF) begin
         slave_rx_en_r <= 1'b0; // see R8
      end
   end

   assign flags_out.cmd_exec     = state_r == hlcs_pkg::ST_EXEC;
   assign flags_out.standby      = state_r == hlcs_pkg::ST_STANDBY;
   assign flags_out.master_req   = master_req_r;
   assign flags_out.slave_tx_req = slave_tx_req_r;
   assign flags_out.slave_rx_en  = slave_rx_en_r;

   // ----------------------------------------------------------------
   // transmit buffer
   // ----------------------------------------------------------------
   assign tx_push     = ce_in && tx_wr_in && tx_cnt_r != hlcs_pkg::TX_DEPTH && !tx_clear;
   assign tx_pop      = ce_in && tx_rd_in && tx_cnt_r != PTR_ZERO_C && !tx_clear;
   assign tx_full_out = tx_cnt_r == hlcs_pkg::TX_DEPTH;

   always_ff @(posedge ref_clk_in) begin
      if (!core_rst_n || tx_clear) begin
         tx_wp_r  <= hlcs_pkg::PTR_ZERO; // see R17
         tx_rp_r  <= hlcs_pkg::PTR_ZERO;
         tx_cnt_r <= hlcs_pkg::PTR_ZERO;
      end else begin
         if (tx_push) begin
            tx_wp_r <= next_ptr(tx_wp_r, hlcs_pkg::TX_DEPTH);
         end
         if (tx_pop) begin
            tx_rp_r <= next_ptr(tx_rp_r, hlcs_pkg::TX_DEPTH);
         end
         if (tx_push != tx_pop) begin
            tx_cnt_r <= tx_push ? 6'(tx_cnt_r + 6'h01) : 6'(tx_cnt_r - 6'h01);
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (tx_push) begin
         tx_mem[tx_wp_r] <= tx_byte_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!core_rst_n) begin
         tx_byte_out <= 8'h00;
      end else if (tx_pop) begin
         tx_byte_out <= tx_mem[tx_rp_r];
      end
   end

   // ----------------------------------------------------------------
   // receive buffer
   // ----------------------------------------------------------------
   assign rx_push      = ce_in && rx_wr_in && rx_cnt_r != hlcs_pkg::RX_DEPTH;
   assign rx_pop       = ce_in && rx_rd_in && rx_cnt_r != PTR_ZERO_C; // see R16
   assign rx_empty_out = rx_cnt_r == PTR_ZERO_C;

   always_ff @(posedge ref_clk_in) begin
      if (!core_rst_n) begin
         rx_wp_r  <= hlcs_pkg::PTR_ZERO;
         rx_rp_r  <= hlcs_pkg::PTR_ZERO;
         rx_cnt_r <= hlcs_pkg::PTR_ZERO;
      end else begin
         if (rx_push) begin
            rx_wp_r <= next_ptr(rx_wp_r, hlcs_pkg::RX_DEPTH);
         end
         if (rx_pop) begin
            rx_rp_r <= next_ptr(rx_rp_r, hlcs_pkg::RX_DEPTH);
         end
         if (rx_push != rx_pop) begin
            rx_cnt_r <= rx_push ? 6'(rx_cnt_r + 6'h01) : 6'(rx_cnt_r - 6'h01);
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rx_push) begin
         rx_mem[rx_wp_r] <= rx_byte_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!core_rst_n) begin
         rx_byte_out <= 8'h00;
      end else if (rx_pop) begin
         rx_byte_out <= rx_mem[rx_rp_r];
      end
   end

   // ----------------------------------------------------------------
   // return code slots: 0 master, 1 slave
   // ----------------------------------------------------------------
   assign slot_ev      = {slave_done_in, master_done_in};
   assign slot_code[0] = master_code_in;
   assign slot_code[1] = slave_code_in;

   generate
      for (genvar g = 0; g < 2; g++) begin : g_slot
         hlcs_rc_slot #(.IS_SLAVE(g == 1)) u_slot (
            .ref_clk_in (ref_clk_in),
            .rst_n_in   (core_rst_n),
            .ce_in      (ce_in),
            .event_in   (slot_ev[g]),
            .code_in    (slot_code[g]),
            .ack_in     (rc_rd_in),
            .code_out   (slot_out[g]),
            .new_out    (rc_new_out[g])
         );
      end
   endgenerate

   assign rc_out.master = slot_out[0];
   assign rc_out.slave  = slot_out[1];
   assign irq_out       = |rc_new_out; // see R6

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence soft_reset_written;
      ce_in && ctrl_wr_in && ctrl_data_in[hlcs_pkg::CTRL_SOFT_RESET_BIT] ##1 soft_rst_r;
   endsequence

   AST_SOFT_RESET: assert property (soft_reset_written |=> flags_out.standby && !flags_out.cmd_exec) // see R2
      else $error("soft reset did not reach standby");

   AST_PIN_RESET: assert property (disable iff (1'b0) !rst_n_in |=> flags_out.standby && tx_cnt_r == 6'h00) // see R2
      else $error("pin reset did not reach standby");

   AST_STANDBY_HOLD: assert property (flags_out.standby && !soft_rst_r // see R3
         && !(ce_in && ctrl_wr_in && ctrl_data_in[hlcs_pkg::CTRL_STANDBY_OFF_BIT]) |=> flags_out.standby)
      else $error("standby left without release");

   AST_TX_CLEAR: assert property (tx_clear && !soft_rst_r |=> tx_cnt_r == 6'h00 && !tx_full_out) // see R17
      else $error("transmit buffer not cleared");

   AST_SLAVE_TX: assert property (done && !soft_rst_r && cmd_r == hlcs_pkg::CMD_SLAVE_TX // see R18
         && tx_cnt_r == 6'h00 && !slave_tx_req_r |=> !slave_tx_req_r)
      else $error("slave transmit started without data");

   AST_EXEC_LEN: assert property (ce_in && flags_out.cmd_exec && cnt_r == 4'h2 ##1 ce_in && !soft_rst_r // see R4
         |=> flags_out.cmd_exec ##0 ce_in && !soft_rst_r |=> !flags_out.cmd_exec)
      else $error("command execution length wrong");

endmodule

`default_nettype wire

/* verification/hlcs_link_model.sv */
// link-side model: pops transmit bytes, pushes receive bytes, raises return codes
// assumes its tasks are called 1 ns after a rising edge of ref_clk_in
`default_nettype none

module hlcs_link_model (
   // clock
   input  wire logic       ref_clk_in,
   // transmit side
   input  wire logic [7:0] tx_byte_in,
   output var  logic       tx_rd_out,
   // receive side
   output var  logic       rx_wr_out,
   output var  logic [7:0] rx_byte_out,
   // completion events
   output var  logic       master_done_out,
   output var  logic [3:0] master_code_out,
   output var  logic       slave_done_out,
   output var  logic [3:0] slave_code_out
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      {tx_rd_out, rx_wr_out, master_done_out, slave_done_out} = 4'h0;
      rx_byte_out = 8'h00;
      master_code_out = 4'h0;
      slave_code_out = 4'h0;
   end

   task automatic step();
      @(posedge ref_clk_in);
      #1;
   endtask

   task automatic pop_tx(output logic [7:0] b);
      tx_rd_out = 1'b1;
      step();
      tx_rd_out = 1'b0;
      b = tx_byte_in;
      step();
   endtask

   task automatic push_rx(input logic [7:0] b);
      rx_wr_out = 1'b1;
      rx_byte_out = b;
      step();
      rx_wr_out = 1'b0;
      rx_byte_out = ~b;
      step();
   endtask

   // same code may come twice in a row
   task automatic raise(input logic slv, input logic [3:0] code);
      master_done_out = !slv;
      slave_done_out = slv;
      master_code_out = code;
      slave_code_out = code;
      step();
      {master_done_out, slave_done_out} = 2'b00;
      master_code_out = ~code;
      slave_code_out = ~code;
   endtask
endmodule

`default_nettype wire

/* verification/hlcs_host_link_ctrl_tb.sv */
// self-checking bench of the host link control sequencer, one task per scenario
// assumes the link model on the far side; inputs move 1 ns after each rising edge
`default_nettype none

module hlcs_host_link_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------
   // signals and instances
   // ------------------------------------------------
   logic                 clk, rst_n, ce, ctrl_wr, cmd_wr, tx_wr, rx_rd, rc_rd;
   logic                 tx_full, rx_empty, irq, tx_rd, rx_wr, m_done, s_done;
   logic [1:0]           rc_new;
   logic [3:0]           m_code, s_code;
   logic [7:0]           ctrl_data, cmd_code, tx_byte, tx_bo, rx_bi, rx_bo;
   hlcs_pkg::hlcs_flag_t flags;
   hlcs_pkg::hlcs_rc_t   rc;
   int                   mismatches = 0;
   int                   n_tests = 0;
   int                   cyc = 0;

   hlcs_host_link_ctrl DUT (
      .ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
      .ctrl_wr_in(ctrl_wr), .ctrl_data_in(ctrl_data), .cmd_wr_in(cmd_wr), .cmd_code_in(cmd_code),
      .flags_out(flags), .tx_full_out(tx_full), .rx_empty_out(rx_empty),
      .tx_wr_in(tx_wr), .tx_byte_in(tx_byte), .tx_rd_in(tx_rd), .tx_byte_out(tx_bo),
      .rx_wr_in(rx_wr), .rx_byte_in(rx_bi), .rx_rd_in(rx_rd), .rx_byte_out(rx_bo),
      .master_done_in(m_done), .master_code_in(m_code), .slave_done_in(s_done), .slave_code_in(s_code),
      .rc_rd_in(rc_rd), .rc_out(rc), .rc_new_out(rc_new), .irq_out(irq)
   );

   hlcs_link_model link (
      .ref_clk_in(clk), .tx_byte_in(tx_bo), .tx_rd_out(tx_rd), .rx_wr_out(rx_wr), .rx_byte_out(rx_bi),
      .master_done_out(m_done), .master_code_out(m_code), .slave_done_out(s_done), .slave_code_out(s_code)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         mismatches++;
         finish_test();
      end
   end

   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic finish_test();
      if (mismatches == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_n(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         mismatches++;
         $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic ctrl(input logic [7:0] d);
      ctrl_wr = 1'b1;
      ctrl_data = d;
      tick(1);
      ctrl_wr = 1'b0;
   endtask

   task automatic pulse_cmd(input logic [7:0] code);
      cmd_wr = 1'b1;
      cmd_code = code;
      tick(1);
      cmd_wr = 1'b0;
   endtask

   task automatic exec_len(output int n);
      n = 0;
      while (flags.cmd_exec === 1'b1 && n < 40) begin
         n++;
         tick(1);
      end
   endtask

   task automatic do_cmd(input logic [7:0] code);
      int n;
      pulse_cmd(code);
      exec_len(n);
      chk_n(n, hlcs_pkg::CMD_EXEC_CYCLES);
   endtask

   task automatic push_tx(input logic [7:0] b);
      tx_wr = 1'b1;
      tx_byte = b;
      tick(1);
      tx_wr = 1'b0;
      tick(1);
   endtask

   task automatic pop_rx(output logic [7:0] b);
      rx_rd = 1'b1;
      tick(1);
      rx_rd = 1'b0;
      b = rx_bo;
      tick(1);
   endtask

   task automatic rc_read();
      rc_rd = 1'b1;
      tick(1);
      rc_rd = 1'b0;
   endtask

   task automatic chk_rst();
      chk_v({3'h0, flags}, 8'h08);
      chk_v({rc_new, irq, rx_empty, tx_full, 3'h0}, 8'h10);
      chk_v(rc, 8'hff);
      chk_v(tx_bo | rx_bo, 8'h00);
   endtask

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_reset();
      rst_n = 1'b0;
      tick(3);
      rst_n = 1'b1;
      chk_rst();
      pulse_cmd(hlcs_pkg::CMD_MASTER_TX);
      chk_v({3'h0, flags}, 8'h08);
      ctrl(8'h02);
      chk_v({3'h0, flags}, 8'h00);
   endtask

   task automatic t_clear();
      int n;
      logic [7:0] b;
      for (int i = 0; i < 3; i++) push_tx(8'(i));
      pulse_cmd(hlcs_pkg::CMD_TX_CLEAR);
      tick(1);
      pulse_cmd(hlcs_pkg::CMD_MASTER_TX);
      exec_len(n);
      chk_n(n, hlcs_pkg::CMD_EXEC_CYCLES - 2);
      chk_v({3'h0, flags}, 8'h00);
      for (int i = 0; i < 33; i++) begin
         chk_v(tx_full, 1'b0);
         push_tx(8'h10 + 8'(i));
      end
      chk_v(tx_full, 1'b1);
      push_tx(8'hee);
      for (int i = 0; i < 33; i++) begin
         link.pop_tx(b);
         chk_v(b, 8'h10 + 8'(i));
      end
   endtask

   task automatic t_slave();
      logic [3:0] codes [5] = '{4'h1, 4'h1, 4'h5, 4'h9, 4'h6};
      do_cmd(hlcs_pkg::CMD_SLAVE_TX);
      chk_v({3'h0, flags}, 8'h00);
      push_tx(8'h5a);
      for (int i = 0; i < 5; i++) begin
         do_cmd((i == 0) ? hlcs_pkg::CMD_SLAVE_TX_CONT : hlcs_pkg::CMD_SLAVE_TX);
         chk_v({3'h0, flags}, 8'h02);
         link.raise(1'b1, codes[i]);
         chk_v({rc.slave, rc_new, irq, flags.slave_tx_req}, {codes[i], 4'ha});
         rc_read();
         chk_v({rc.slave, rc_new, irq, 1'b0}, {(codes[i] == 4'h6) ? 4'h6 : 4'hf, 4'h0});
      end
   endtask

   task automatic t_master();
      logic [7:0] cmds [4] = '{hlcs_pkg::CMD_MASTER_TX, hlcs_pkg::CMD_MASTER_TX_RESUME,
                               hlcs_pkg::CMD_MASTER_RX, hlcs_pkg::CMD_MASTER_TX};
      logic [3:0] codes [4] = '{4'h1, 4'h1, 4'h5, 4'h3};
      for (int i = 0; i < 4; i++) begin
         do_cmd(cmds[i]);
         chk_v({3'h0, flags}, 8'h04);
         link.raise(1'b0, codes[i]);
         chk_v({rc.master, rc_new, irq, flags.master_req}, {codes[i], 4'h6});
         rc_read();
         chk_v({rc.master, rc_new, irq, 1'b0}, {(codes[i] == 4'h3) ? 4'h3 : 4'hf, 4'h0});
      end
      do_cmd(hlcs_pkg::CMD_SLAVE_RX_ON);
      chk_v({3'h0, flags}, 8'h01);
      do_cmd(hlcs_pkg::CMD_SLAVE_RX_OFF);
      chk_v({3'h0, flags}, 8'h00);
      ce = 1'b0;
      pulse_cmd(hlcs_pkg::CMD_SLAVE_RX_ON);
      ce = 1'b1;
      chk_v({3'h0, flags}, 8'h00);
      rc_rd = 1'b1;
      link.raise(1'b1, 4'h9);
      rc_rd = 1'b0;
      chk_v({rc.slave, rc_new, irq, 1'b0}, 8'h9a);
      tick(2);
      chk_v({rc.slave, rc_new, irq, 1'b0}, 8'h9a);
      rc_read();
      chk_v({rc.slave, rc_new, irq, 1'b0}, 8'hf0);
   endtask

   task automatic t_rx();
      logic [7:0] b;
      for (int i = 0; i < 41; i++) link.push_rx(8'h40 + 8'(i));
      for (int i = 0; i < 40; i++) begin
         chk_v(rx_empty, 1'b0);
         pop_rx(b);
         chk_v(b, 8'h40 + 8'(i));
      end
      chk_v(rx_empty, 1'b1);
      pop_rx(b);
      chk_v(b, 8'h67);
   endtask

   task automatic t_soft();
      link.raise(1'b0, 4'h3);
      ctrl(8'h01);
      chk_v({3'h0, flags}, 8'h00);
      tick(1);
      chk_rst();
      link.raise(1'b1, 4'h6);
      t_reset();
   endtask

   initial begin
      {rst_n, ctrl_wr, cmd_wr, tx_wr, rx_rd, rc_rd} = 6'h00;
      ce = 1'b1;
      {ctrl_data, cmd_code, tx_byte} = 24'h00_0000;
      t_reset();
      t_clear();
      t_slave();
      t_master();
      t_rx();
      t_soft();
      finish_test();
   end
endmodule

`default_nettype wire
